// ---- bench/term_switches.sv ----
/*
 Operator switches on the enable, trigger and direction terminals.
 Assumes the bench sets wanted levels at the falling clock edge.
*/
`timescale 1ns/1ps
module term_switches
   import run_ctl_pkg::*;
(
   // Wanted and actual levels
   input wire term_t want,
   output term_t pins
);
   // ====================
   // Contacts
   // Ideal contacts: bounce is filtered before this block
   assign pins = want;
endmodule

// ---- bench/three_wire_run_control_test.sv ----
/*
 Random and corner stimulus for the run control, checked against a
 bench model. Assumes the switch model passes levels unchanged.
*/
`timescale 1ns/1ps
module three_wire_run_control_test
   import run_ctl_pkg::*;
;
   // ====================
   // Signals and model
   logic core_clk = 0;
   logic rst = 1;
   logic [MODE_W-1:0] term_mode = MODE_THREE_WIRE;
   term_t want = '0;
   term_t pins;
   cmd_t got;
   cmd_t exp = '0;
   logic pt = 0;
   logic pd = 0;
   logic ok;
   int seed = 23;
   int bad_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   always #5 core_clk = ~core_clk;
   assign ok = pins.stop_enable && term_mode == MODE_THREE_WIRE;
   term_switches sw (.want(want), .pins(pins));
   three_wire_run_control dut (.core_clk(core_clk), .rst(rst),
      .term_mode(term_mode), .stop_enable(pins.stop_enable),
      .run_trigger_input(pins.run_trigger_input),
      .direction_select_input(pins.direction_select_input),
      .run_cmd(got.run), .reverse_cmd(got.reverse),
      .start_pulse(got.start_pulse), .stop_pulse(got.stop_pulse));
   // Model runs on the same edge; inputs only move at falling edges
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         exp = '0;
         pt = 0;
         pd = 0;
      end else begin
         exp.start_pulse = 0;
         exp.stop_pulse = 0;
         if (exp.run && !ok) begin
            exp.run = 0;
            exp.stop_pulse = 1;
         end else if (exp.run) begin
            exp.reverse ^= pins.direction_select_input ^ pd;
         end else if (ok && pins.run_trigger_input && !pt) begin
            exp.run = 1;
            exp.reverse = pins.direction_select_input;
            exp.start_pulse = 1;
         end
         pt = pins.run_trigger_input;
         pd = pins.direction_select_input;
      end
   end
   // ====================
   // Checks and verdict
   task automatic finish_test;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 6000) begin
         bad_count++;
         finish_test();
      end
   end
   initial begin
      repeat (12) @(negedge core_clk);
      rst = 0;
      for (int i = 0; i < 4000; i++) begin
         @(negedge core_clk);
         cmp_count++;
         if (got !== exp) begin
            bad_count++;
            $display("MISMATCH cmd exp %h got %h", exp, got);
         end
         // Reset once in mid-run; mode leaves two now and then
         rst = (i == 2000);
         term_mode = (($random(seed) & 15) == 0) ? 4'h5 : MODE_THREE_WIRE;
         want.stop_enable = ($random(seed) & 7) != 0;
         want.run_trigger_input = $random(seed);
         want.direction_select_input = (i % 3 == 0) ? $random(seed) : pd;
      end
      finish_test();
   end
endmodule

// ---- logic/edge_track.sv ----
/*
 Holds the previous sample of one terminal and flags its edges.
 Assumes the input is synchronous to core_clk.
*/
`timescale 1ns/1ps
module edge_track
   import run_ctl_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Level in, edges out
   input wire logic level,
   output logic rise,
   output logic change
);
   typedef struct packed {
      logic prev;
   } edge_state_t;

   edge_state_t state;
   edge_state_t next_state;

   always_comb begin
      next_state = state;
      next_state.prev = level;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // Low at reset, so an input already closed at reset is seen as a rising edge
   assign rise = level & ~state.prev;
   assign change = level ^ state.prev;
endmodule

// ---- logic/run_ctl_pkg.sv ----
/*
 Constants and carrier types for the three-wire run/stop and direction
 command logic. Assumes one sampling clock and terminal levels already
 debounced and synchronous to it.
*/
package run_ctl_pkg;
   localparam int MODE_W = 4;
   localparam logic [MODE_W-1:0] MODE_THREE_WIRE = 4'h2;
   localparam logic RUN_RESET = 1'b0;
   localparam logic DIR_RESET = 1'b0;

   // Run state, Gray along idle -> run
   typedef enum logic [0:0] {
      ST_STOP = 1'b0,
      ST_RUN = 1'b1
   } run_state_t;

   // Sampled terminal levels
   typedef struct packed {
      logic stop_enable;
      logic run_trigger_input;
      logic direction_select_input;
   } term_t;

   // Commands towards the drive
   typedef struct packed {
      logic run;
      logic reverse;
      logic start_pulse;
      logic stop_pulse;
   } cmd_t;
endpackage

// ---- logic/three_wire_run_control.sv ----
/*
 Three-wire run control: enable, run trigger and direction terminals
 give run/stop and direction commands to the drive.
 Assumes terminals are debounced and synchronous to core_clk, and the
 mode setting is held steady by the parameter logic outside.
*/
`timescale 1ns/1ps
module three_wire_run_control
   import run_ctl_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Mode setting
   input wire logic [MODE_W-1:0] term_mode,
   // Terminals
   input wire logic stop_enable,
   input wire logic run_trigger_input,
   input wire logic direction_select_input,
   // Drive commands
   output logic run_cmd,
   output logic reverse_cmd,
   output logic start_pulse,
   output logic stop_pulse
);
   // ===============================================================
   // State
   typedef struct packed {
      run_state_t st;
      cmd_t cmd;
   } ctl_state_t;

   ctl_state_t state;
   ctl_state_t next_state;
   term_t term;
   logic trig_rise;
   logic dir_change;
   logic mode_on;

   assign term = '{stop_enable, run_trigger_input, direction_select_input};

   // ===============================================================
   // Edge detection
   edge_track u_trig (
      .core_clk(core_clk),
      .rst(rst),
      .level(term.run_trigger_input),
      .rise(trig_rise),
      .change()
   );

   edge_track u_dir (
      .core_clk(core_clk),
      .rst(rst),
      .level(term.direction_select_input),
      .rise(),
      .change(dir_change)
   );

   assign mode_on = (term_mode == MODE_THREE_WIRE);

   // ===============================================================
   // Next state
   always_comb begin
      next_state = state;
      next_state.cmd.start_pulse = 1'b0;
      next_state.cmd.stop_pulse = 1'b0;
      case (state.st)
         ST_STOP: begin
            // Edge with enable open is dropped, not remembered
            if (mode_on && term.stop_enable && trig_rise) begin
               next_state.st = ST_RUN;
               next_state.cmd.run = 1'b1;
               next_state.cmd.reverse = term.direction_select_input;
               next_state.cmd.start_pulse = 1'b1;
            end
         end
         ST_RUN: begin
            if (!mode_on || !term.stop_enable) begin
               next_state.st = ST_STOP;
               next_state.cmd.run = 1'b0;
               next_state.cmd.stop_pulse = 1'b1;
            end else if (dir_change) begin
               next_state.cmd.reverse = ~state.cmd.reverse;
            end
         end
         default: begin
            next_state.st = ST_STOP;
            next_state.cmd.run = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state.st <= ST_STOP;
         state.cmd.run <= RUN_RESET;
         state.cmd.reverse <= DIR_RESET;
         state.cmd.start_pulse <= 1'b0;
         state.cmd.stop_pulse <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   assign run_cmd = state.cmd.run;
   assign reverse_cmd = state.cmd.reverse;
   assign start_pulse = state.cmd.start_pulse;
   assign stop_pulse = state.cmd.stop_pulse;

   // ===============================================================
   // Checks
   mode_gate_a: assert property (@(posedge core_clk) disable iff (rst)
      (term_mode != MODE_THREE_WIRE) |=> !run_cmd)
      else $error("run while mode not three-wire");

   enable_gate_a: assert property (@(posedge core_clk) disable iff (rst)
      $rose(run_cmd) |-> $past(stop_enable))
      else $error("run started with enable open");

   edge_start_a: assert property (@(posedge core_clk) disable iff (rst)
      (mode_on && stop_enable && trig_rise && !run_cmd) |=>
      (run_cmd && start_pulse))
      else $error("trigger edge did not start run");

   start_dir_a: assert property (@(posedge core_clk) disable iff (rst)
      $rose(run_cmd) |-> (reverse_cmd == $past(direction_select_input)))
      else $error("start direction wrong");

   open_stop_a: assert property (@(posedge core_clk) disable iff (rst)
      (run_cmd && !stop_enable) |=> (!run_cmd && stop_pulse))
      else $error("enable open did not stop");

   dir_flip_a: assert property (@(posedge core_clk) disable iff (rst)
      (run_cmd && mode_on && stop_enable && dir_change) |=>
      (reverse_cmd != $past(reverse_cmd)))
      else $error("direction change not followed");

   // One cycle only: enable may close with a fresh edge right after
   open_ignore_a: assert property (@(posedge core_clk) disable iff (rst)
      (!run_cmd && !stop_enable) |=>
      !run_cmd)
      else $error("run started with enable open");

   // ===============================================================
   // Pulse and hold checks
   start_once_a: assert property (@(posedge core_clk) disable iff (rst)
      start_pulse |=>
      !start_pulse)
      else $error("start pulse longer than one cycle");

   stop_once_a: assert property (@(posedge core_clk) disable iff (rst)
      stop_pulse |=>
      !stop_pulse)
      else $error("stop pulse longer than one cycle");

   start_mark_a: assert property (@(posedge core_clk) disable iff (rst)
      start_pulse |->
      (run_cmd && !$past(run_cmd)))
      else $error("start pulse without run start");

   stop_mark_a: assert property (@(posedge core_clk) disable iff (rst)
      stop_pulse |->
      (!run_cmd && $past(run_cmd)))
      else $error("stop pulse without run end");

   rise_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
      $rose(run_cmd) |->
      start_pulse)
      else $error("run start without start pulse");

   fall_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
      $fell(run_cmd) |->
      stop_pulse)
      else $error("run end without stop pulse");

   // Direction is taken at start and follows changes while running, never while stopped
   idle_dir_a: assert property (@(posedge core_clk) disable iff (rst)
      (!run_cmd && !$past(run_cmd)) |->
      $stable(reverse_cmd))
      else $error("direction moved while stopped");

   run_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      (run_cmd && mode_on && stop_enable && !dir_change) |=>
      (run_cmd && $stable(reverse_cmd) && !start_pulse))
      else $error("run or direction moved without cause");

   // Stop wins over a direction change in the same cycle
   stop_first_a: assert property (@(posedge core_clk) disable iff (rst)
      (run_cmd && !stop_enable && dir_change) |=>
      (!run_cmd && $stable(reverse_cmd)))
      else $error("direction flipped on stop");

   mode_stop_a: assert property (@(posedge core_clk) disable iff (rst)
      (run_cmd && !mode_on) |=>
      (!run_cmd && stop_pulse))
      else $error("leaving mode did not stop");

   level_no_start_a: assert property (@(posedge core_clk) disable iff (rst)
      (!run_cmd && !trig_rise) |=>
      !run_cmd)
      else $error("run started on trigger level");

   pulse_excl_a: assert property (@(posedge core_clk) disable iff (rst)
      !(start_pulse && stop_pulse))
      else $error("start and stop pulse together");

   enable_keep_a: assert property (@(posedge core_clk) disable iff (rst)
      (run_cmd && mode_on && stop_enable) |=>
      run_cmd)
      else $error("run dropped with enable closed");

   stop_keep_dir_a: assert property (@(posedge core_clk) disable iff (rst)
      $fell(run_cmd) |->
      $stable(reverse_cmd))
      else $error("direction lost at stop");

   trig_run_a: assert property (@(posedge core_clk) disable iff (rst)
      (run_cmd && trig_rise) |=>
      !start_pulse)
      else $error("trigger edge restarted a running drive");

   open_no_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
      (!run_cmd && !stop_enable) |=>
      !start_pulse)
      else $error("start pulse with enable open");

   mode_no_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
      (!run_cmd && !mode_on) |=>
      !start_pulse)
      else $error("start pulse outside three-wire mode");

   idle_no_stop_a: assert property (@(posedge core_clk) disable iff (rst)
      !run_cmd |=>
      !stop_pulse)
      else $error("stop pulse while already stopped");
endmodule
